// ### rtl/line_mem_pkg.sv
// Shared constants and carrier types for the line field memory ports
package line_mem_pkg;
    localparam int LUMA_W = 8;
    localparam int CHROMA_W = 4;
    localparam int LINE_ADDR_W = 9;
    localparam int BIT_ADDR_W = 10;
    localparam int LINE_WORDS = 768;
    localparam logic [BIT_ADDR_W-1:0] LAST_BIT = 10'h2ff;
    localparam logic [BIT_ADDR_W-1:0] BIT_ZERO = 10'h000;
    localparam logic [LINE_ADDR_W-1:0] LINE_ZERO = 9'h000;
    localparam logic [3:0] LINE_SHIFT_MAX = 4'h9;
    localparam logic [3:0] BIT_SHIFT_MAX = 4'ha;
    localparam logic [3:0] SHIFT_ZERO = 4'h0;

    // One 12-bit pixel word, luma plus chroma
    typedef struct packed {
        logic [LUMA_W-1:0] luma;
        logic [CHROMA_W-1:0] chroma;
    } pixel_type;

    // Buffered write entry: data and its line position
    typedef struct packed {
        pixel_type pix;
        logic [BIT_ADDR_W-1:0] addr;
    } wr_entry_type;

    // Write side sequencing state
    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_ADDR_SET = 2'b01,
        WR_STREAM = 2'b10
    } wr_state_type;
endpackage : line_mem_pkg

// ### rtl/line_field_memory_ports.sv
// Write port, line buffer and two read ports (port 2 split into luma and chroma) of a line field memory
//
// Overview of operation
// - Write enable and mask enable capture 12-bit word
// - Mask low still advances pointer, drops data
// - Write enable low holds pointer, no data
// - Write pointer stops at line end
// - Address enable loads serial line/bit addresses
// - Write line address is nine serial bits
// - Write start bit address is ten bits
// - Write reset high is one-cycle reset cycle
// - Reset cycle: enable low zeroes, high restores
// - Line increment advances shared write line
// - Write reset transfers write register to array
// - Shared clock: read lags write one cycle
// - Port-1 read gives 12-bit word, advances pointer
// - Port-2 luma read gives 8-bit word
// - Port-2 chroma read gives 4-bit word
// - Three independent read pointers saturate at line end
// - Port-1 shared clock, port-2 separate enables
// - Port-2 chroma enable governs its drivers
// - Read addresses: nine line, ten bit bits
// - Read reset: enable low zeroes, high restores
// - Read reset selects mode from enable levels
`timescale 1ns/1ps
`default_nettype none
module line_field_memory_ports (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write port
    input wire logic write_enable_bit_reset_sel,
    input wire logic input_mask_enable,
    input wire logic [line_mem_pkg::LUMA_W-1:0] luma_write_data,
    input wire logic [line_mem_pkg::CHROMA_W-1:0] chroma_write_data,
    input wire logic write_reset_transfer,
    input wire logic write_line_increment,
    input wire logic write_addr_enable_line_reset_sel,
    input wire logic write_line_addr_serial,
    input wire logic write_bit_addr_serial,
    // Write buffer back-pressure toward the source
    output logic write_ready,
    // Port-1 read control
    input wire logic port1_read_enable,
    input wire logic port1_read_reset,
    input wire logic port1_addr_enable,
    input wire logic port1_read_line_addr,
    input wire logic port1_read_bit_addr,
    // Port-2 read control
    input wire logic port2_luma_read_enable,
    input wire logic port2_chroma_read_enable,
    input wire logic port2_read_reset,
    input wire logic port2_addr_enable,
    input wire logic port2_read_line_addr,
    input wire logic port2_luma_read_bit_addr,
    input wire logic port2_chroma_read_bit_addr,
    // Read data and output enables
    output line_mem_pkg::pixel_type port1_out,
    output logic port1_out_oe,
    output logic [line_mem_pkg::LUMA_W-1:0] port2_luma_out,
    output logic port2_luma_out_oe,
    output logic [line_mem_pkg::CHROMA_W-1:0] port2_chroma_out,
    output logic port2_chroma_out_oe,
    // Current write line, for the controller's bookkeeping
    output logic [line_mem_pkg::LINE_ADDR_W-1:0] write_line_r_out
);
    import line_mem_pkg::*;

    // Write register and one line of array storage, flip-flops by index
    pixel_type write_reg [LINE_WORDS]; // Staging line for writes
    pixel_type line_array [LINE_WORDS]; // Transferred line contents

    // Write address registers and counters
    logic [LINE_ADDR_W-1:0] wr_line_sh_r; // Serial line shift
    logic [BIT_ADDR_W-1:0] wr_bit_sh_r; // Serial bit shift
    logic [3:0] wr_line_cnt_r; // Serial line bits taken
    logic [3:0] wr_bit_cnt_r; // Serial bit bits taken
    logic [BIT_ADDR_W-1:0] wr_bit_preset_r; // Stored start bit
    logic [LINE_ADDR_W-1:0] wr_line_r; // Write line counter
    logic [BIT_ADDR_W-1:0] wr_ptr_r; // Write pointer
    wr_state_type wr_state_r; // Write sequencing state

    // Cycle kinds on the write side
    logic wr_reset_cycle; // Reset or transfer cycle
    logic wr_addr_cycle; // Serial address set cycle
    logic wr_advance; // Pointer step this cycle
    logic wr_capture; // Word accepted this cycle
    assign wr_reset_cycle = write_reset_transfer;
    assign wr_addr_cycle = write_addr_enable_line_reset_sel &&
        !write_reset_transfer;
    // No advance during address setting; stalls when buffer full
    assign wr_advance = write_enable_bit_reset_sel && !wr_reset_cycle &&
        !wr_addr_cycle && write_ready;
    assign wr_capture = wr_advance && input_mask_enable;

    // Serial write address shift registers
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_line_sh_r <= LINE_ZERO;
            wr_bit_sh_r <= BIT_ZERO;
            wr_line_cnt_r <= SHIFT_ZERO;
            wr_bit_cnt_r <= SHIFT_ZERO;
        end else if (wr_addr_cycle) begin
            // MSB first; extra bits beyond the width are ignored
            if (wr_line_cnt_r != LINE_SHIFT_MAX) begin
                wr_line_sh_r <= {wr_line_sh_r[LINE_ADDR_W-2:0],
                    write_line_addr_serial};
                wr_line_cnt_r <= wr_line_cnt_r + 4'h1;
            end
            if (wr_bit_cnt_r != BIT_SHIFT_MAX) begin
                wr_bit_sh_r <= {wr_bit_sh_r[BIT_ADDR_W-2:0],
                    write_bit_addr_serial};
                wr_bit_cnt_r <= wr_bit_cnt_r + 4'h1;
            end
        end else begin
            wr_line_cnt_r <= SHIFT_ZERO;
            wr_bit_cnt_r <= SHIFT_ZERO;
        end
    end

    // Write sequencing: loads addresses when the set period ends
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_state_r <= WR_IDLE;
            wr_line_r <= LINE_ZERO;
            wr_bit_preset_r <= BIT_ZERO;
            wr_ptr_r <= BIT_ZERO;
        end else begin
            case (wr_state_r)
                WR_IDLE, WR_STREAM: begin
                    if (wr_addr_cycle) begin
                        wr_state_r <= WR_ADDR_SET;
                    end else if (wr_reset_cycle) begin
                        // Reset cycle: bit zero or stored preset
                        wr_ptr_r <= write_enable_bit_reset_sel ?
                            wr_bit_preset_r : BIT_ZERO;
                        if (write_line_increment) begin
                            wr_line_r <= wr_line_r + 9'h001;
                        end
                        wr_state_r <= WR_STREAM;
                    end else if (wr_advance && wr_ptr_r != LAST_BIT) begin
                        wr_ptr_r <= wr_ptr_r + 10'h001;
                    end
                end
                WR_ADDR_SET: begin
                    if (!wr_addr_cycle) begin
                        // Latch assembled addresses as new start
                        wr_line_r <= wr_line_sh_r;
                        wr_bit_preset_r <= wr_bit_sh_r;
                        wr_ptr_r <= wr_bit_sh_r;
                        wr_state_r <= WR_STREAM;
                    end
                end
                default: begin
                    wr_state_r <= WR_IDLE;
                end
            endcase
        end
    end

    // Limitation: a word taken on the cycle just before a transfer is
    // still queued when the copy runs, so it misses that line; keep
    // one idle write cycle ahead of every transfer cycle.
    // Two-entry buffer between the data pins and the write register
    wr_entry_type buf_mem_r [2]; // Buffer slots
    logic [1:0] buf_cnt_r; // Occupancy
    logic buf_wp_r; // Fill slot index
    logic buf_rp_r; // Drain slot index
    logic buf_in_valid; // Filling side valid
    logic buf_out_valid; // Draining side valid
    logic buf_out_ready; // Draining side ready
    logic buf_push; // Word enters
    logic buf_pop; // Word leaves
    assign buf_in_valid = wr_capture;
    assign buf_out_valid = buf_cnt_r != 2'h0;
    // Drain stalls during a transfer so the staged line is consistent
    assign buf_out_ready = !wr_reset_cycle;
    assign buf_push = buf_in_valid && write_ready;
    assign buf_pop = buf_out_valid && buf_out_ready;

    // Buffer occupancy and pointers
    always_ff @(posedge clk) begin
        if (rst) begin
            buf_cnt_r <= 2'h0;
            buf_wp_r <= 1'b0;
            buf_rp_r <= 1'b0;
            write_ready <= 1'b1;
        end else begin
            if (buf_push) begin
                buf_mem_r[buf_wp_r] <= '{pix: '{luma: luma_write_data,
                    chroma: chroma_write_data}, addr: wr_ptr_r};
                buf_wp_r <= !buf_wp_r;
            end
            if (buf_pop) begin
                buf_rp_r <= !buf_rp_r;
            end
            case ({buf_push, buf_pop})
                2'b10: begin
                    buf_cnt_r <= buf_cnt_r + 2'h1;
                    write_ready <= buf_cnt_r == 2'h0;
                end
                2'b01: begin
                    buf_cnt_r <= buf_cnt_r - 2'h1;
                    write_ready <= 1'b1;
                end
                default: begin
                    write_ready <= buf_cnt_r != 2'h2;
                end
            endcase
        end
    end

    // Per-word write register and array transfer
    genvar gi;
    generate
        for (gi = 0; gi < LINE_WORDS; gi++) begin : g_word
            always_ff @(posedge clk) begin
                if (buf_pop &&
                    buf_mem_r[buf_rp_r].addr == BIT_ADDR_W'(gi)) begin
                    write_reg[gi] <= buf_mem_r[buf_rp_r].pix;
                end
            end
            // Transfer on the write reset cycle moves the whole line
            always_ff @(posedge clk) begin
                if (wr_reset_cycle) begin
                    line_array[gi] <= write_reg[gi];
                end
            end
        end
    endgenerate

    // Read address serial capture, one bit slot per pointer, one line slot per port
    logic [LINE_ADDR_W-1:0] rd_line_sh_r [2]; // Port line shifts
    logic [BIT_ADDR_W-1:0] rd_bit_sh_r [3]; // Pointer bit shifts
    logic [BIT_ADDR_W-1:0] rd_preset_r [3]; // Stored start bits
    logic [BIT_ADDR_W-1:0] rd_ptr_r [3]; // Read pointers
    logic [2:0] rd_en; // Per-pointer enable
    logic [2:0] rd_rst; // Per-pointer reset cycle
    logic [2:0] rd_set; // Per-pointer address set
    logic [2:0] rd_bit_in; // Per-pointer serial bit
    assign rd_en = {port2_chroma_read_enable, port2_luma_read_enable,
        port1_read_enable};
    assign rd_rst = {port2_read_reset, port2_read_reset,
        port1_read_reset};
    assign rd_set = {port2_addr_enable && !port2_read_reset,
        port2_addr_enable && !port2_read_reset,
        port1_addr_enable && !port1_read_reset};
    assign rd_bit_in = {port2_chroma_read_bit_addr,
        port2_luma_read_bit_addr, port1_read_bit_addr};

    // Line addresses are kept only; one line of storage is modelled
    // Port line address shift registers
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_line_sh_r[0] <= LINE_ZERO;
            rd_line_sh_r[1] <= LINE_ZERO;
        end else begin
            if (rd_set[0]) begin
                rd_line_sh_r[0] <= {rd_line_sh_r[0][LINE_ADDR_W-2:0],
                    port1_read_line_addr};
            end
            if (rd_set[1]) begin
                rd_line_sh_r[1] <= {rd_line_sh_r[1][LINE_ADDR_W-2:0],
                    port2_read_line_addr};
            end
        end
    end

    // Three independent read pointers
    generate
        for (gi = 0; gi < 3; gi++) begin : g_rd
            always_ff @(posedge clk) begin
                if (rst) begin
                    rd_bit_sh_r[gi] <= BIT_ZERO;
                    rd_preset_r[gi] <= BIT_ZERO;
                    rd_ptr_r[gi] <= BIT_ZERO;
                end else if (rd_set[gi]) begin
                    // Serial start bit, last ten bits win
                    rd_bit_sh_r[gi] <= {rd_bit_sh_r[gi][BIT_ADDR_W-2:0],
                        rd_bit_in[gi]};
                    rd_preset_r[gi] <= {rd_bit_sh_r[gi][BIT_ADDR_W-2:0],
                        rd_bit_in[gi]};
                    rd_ptr_r[gi] <= {rd_bit_sh_r[gi][BIT_ADDR_W-2:0],
                        rd_bit_in[gi]};
                end else if (rd_rst[gi]) begin
                    rd_ptr_r[gi] <= rd_en[gi] ? rd_preset_r[gi]
                        : BIT_ZERO;
                end else if (rd_en[gi] && rd_ptr_r[gi] != LAST_BIT) begin
                    rd_ptr_r[gi] <= rd_ptr_r[gi] + 10'h001;
                end
            end
        end
    endgenerate

    // Read data registers: the word leaves one cycle after the pointer
    // edge, which gives the one-cycle lag behind writes on a shared clock
    always_ff @(posedge clk) begin
        if (rst) begin
            port1_out <= '0;
            port2_luma_out <= '0;
            port2_chroma_out <= '0;
        end else begin
            if (rd_en[0]) begin
                port1_out <= line_array[rd_ptr_r[0]];
            end
            if (rd_en[1]) begin
                port2_luma_out <= line_array[rd_ptr_r[1]].luma;
            end
            if (rd_en[2]) begin
                port2_chroma_out <= line_array[rd_ptr_r[2]].chroma;
            end
        end
    end

    // Output enables follow their read enables
    always_ff @(posedge clk) begin
        if (rst) begin
            port1_out_oe <= 1'b0;
            port2_luma_out_oe <= 1'b0;
            port2_chroma_out_oe <= 1'b0;
        end else begin
            port1_out_oe <= port1_read_enable;
            port2_luma_out_oe <= port2_luma_read_enable;
            port2_chroma_out_oe <= port2_chroma_read_enable;
        end
    end

    // Line counter mirrored out for the controller
    always_ff @(posedge clk) begin
        if (rst) begin
            write_line_r_out <= LINE_ZERO;
        end else begin
            write_line_r_out <= wr_line_r;
        end
    end
endmodule : line_field_memory_ports
`default_nettype wire

// ### dv/addr_feeder.sv
// Serial address feeder model of the controlling video logic
`timescale 1ns/1ps
`default_nettype none
module addr_feeder (
    // Clock, reset and request
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [9:0] a_val,
    input wire logic [9:0] b_val,
    // Serial address pins
    output logic addr_en,
    output logic line_ser,
    output logic a_ser,
    output logic b_ser
);
    logic [3:0] cnt_r; // Bits still to shift out
    logic [9:0] a_r; // First bit address shifter
    logic [9:0] b_r; // Second bit address shifter
    // Ten MSB-first shifts carry the 9-bit line and 10-bit bit address
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= 4'h0;
        end else if (go && cnt_r == 4'h0) begin
            cnt_r <= 4'ha;
            a_r <= a_val;
            b_r <= b_val;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
            a_r <= {a_r[8:0], 1'b0};
            b_r <= {b_r[8:0], 1'b0};
        end else begin
            // Released pins toggle, so a stale bit never passes as data
            a_r <= ~a_r;
            b_r <= ~b_r;
        end
    end
    // Enable only while bits go out; the bench never reads or writes then
    assign addr_en = (cnt_r != 4'h0);
    assign a_ser = a_r[9];
    assign b_ser = b_r[9];
    // Line zero is sent, padded with a leading zero
    assign line_ser = addr_en ? 1'b0 : a_r[0];
endmodule : addr_feeder
`default_nettype wire

// ### dv/line_field_memory_chk.sv
// Concurrent checks on the line field memory port pins
`timescale 1ns/1ps
`default_nettype none
module line_field_memory_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controls
    input wire logic write_enable_bit_reset_sel,
    input wire logic input_mask_enable,
    input wire logic write_reset_transfer,
    input wire logic write_line_increment,
    input wire logic write_addr_enable_line_reset_sel,
    input wire logic port1_read_enable,
    input wire logic port1_read_reset,
    input wire logic port2_luma_read_enable,
    input wire logic port2_chroma_read_enable,
    input wire logic port2_read_reset,
    // Outputs watched
    input wire logic write_ready,
    input wire line_mem_pkg::pixel_type port1_out,
    input wire logic port1_out_oe,
    input wire logic [line_mem_pkg::LUMA_W-1:0] port2_luma_out,
    input wire logic port2_luma_out_oe,
    input wire logic [line_mem_pkg::CHROMA_W-1:0] port2_chroma_out,
    input wire logic port2_chroma_out_oe,
    input wire logic [line_mem_pkg::LINE_ADDR_W-1:0] write_line_r_out
);
    import line_mem_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Drivers turn on after an enabled edge, off and frozen otherwise
    a_p1_on: assert property (
        port1_read_enable && !port1_read_reset |=> port1_out_oe)
        else $error("port1 not driven after read");
    a_p1_off: assert property (
        !port1_read_enable |=> !port1_out_oe && $stable(port1_out))
        else $error("port1 moved while disabled");
    a_y2_on: assert property (
        port2_luma_read_enable && !port2_read_reset |=> port2_luma_out_oe)
        else $error("port2 luma not driven");
    a_y2_off: assert property (
        !port2_luma_read_enable |=> !port2_luma_out_oe
        && $stable(port2_luma_out)) else $error("port2 luma moved");
    a_c2_on: assert property (
        port2_chroma_read_enable && !port2_read_reset |=> port2_chroma_out_oe)
        else $error("port2 chroma not driven");
    a_c2_off: assert property (
        !port2_chroma_read_enable |=> !port2_chroma_out_oe
        && $stable(port2_chroma_out)) else $error("port2 chroma moved");
    // Quiet outputs and an open buffer right after reset
    a_reset_idle: assert property ($fell(rst) |-> write_ready
        && !port1_out_oe && !port2_luma_out_oe && !port2_chroma_out_oe)
        else $error("outputs busy after reset");
    // The buffer drains by itself, so a stall is short
    a_ready_back: assert property (
        !write_ready |-> ##[1:8] write_ready)
        else $error("write buffer stuck");
    a_line_step: assert property (
        write_reset_transfer && write_line_increment |=> ##1
        write_line_r_out == $past(write_line_r_out, 2) + 9'h001)
        else $error("write line not stepped");
    a_line_hold: assert property (
        (!write_reset_transfer && !write_addr_enable_line_reset_sel)[*3]
        |=> $stable(write_line_r_out)) else $error("write line drifted");
    c_p1_read: cover property (port1_read_enable ##1 port1_out_oe);
    c_masked: cover property (write_enable_bit_reset_sel
        && !input_mask_enable && !write_reset_transfer);
    c_both2: cover property (port2_luma_read_enable
        && port2_chroma_read_enable);
endmodule : line_field_memory_chk
bind line_field_memory_ports line_field_memory_chk u_chk (.*);
`default_nettype wire

// ### dv/line_field_memory_ports_tb.sv
// Self-checking bench for the line field memory ports
`timescale 1ns/1ps
`default_nettype none
module line_field_memory_ports_tb;
    import line_mem_pkg::*;
    logic clk, rst, write_enable_bit_reset_sel, input_mask_enable;
    logic [LUMA_W-1:0] luma_write_data;
    logic [CHROMA_W-1:0] chroma_write_data;
    logic write_reset_transfer, write_line_increment, write_ready;
    logic write_addr_enable_line_reset_sel, write_line_addr_serial;
    logic write_bit_addr_serial, port1_read_enable, port1_read_reset;
    logic port1_addr_enable, port1_read_line_addr, port1_read_bit_addr;
    logic port2_luma_read_enable, port2_chroma_read_enable;
    logic port2_read_reset, port2_addr_enable, port2_read_line_addr;
    logic port2_luma_read_bit_addr, port2_chroma_read_bit_addr;
    pixel_type port1_out;
    logic port1_out_oe, port2_luma_out_oe, port2_chroma_out_oe;
    logic [LUMA_W-1:0] port2_luma_out;
    logic [CHROMA_W-1:0] port2_chroma_out;
    logic [LINE_ADDR_W-1:0] write_line_r_out;
    logic [2:0] go; // Feeder requests: write, port 1, port 2
    logic [9:0] wa, p1a, p2y, p2c; // Start bit addresses to feed
    logic [11:0] y2, c2; // Port 2 outputs widened for comparison
    pixel_type wreg [LINE_WORDS]; // Model of the write register
    pixel_type mem [LINE_WORDS]; // Model of the stored line
    logic [11:0] q1 [$], qy [$], qc [$]; // Expected read words
    logic s1, sy, sc; // A read was taken at the last edge
    int n_mismatch, checks, cyc, wp, wpre, p1, p1pre, py, pc, pypre, pcpre;

    line_field_memory_ports DUT (.*);
    addr_feeder u_wf (.clk(clk), .rst(rst), .go(go[0]), .a_val(wa),
        .b_val(10'h000), .addr_en(write_addr_enable_line_reset_sel),
        .line_ser(write_line_addr_serial), .a_ser(write_bit_addr_serial),
        .b_ser());
    addr_feeder u_f1 (.clk(clk), .rst(rst), .go(go[1]), .a_val(p1a),
        .b_val(10'h000), .addr_en(port1_addr_enable),
        .line_ser(port1_read_line_addr), .a_ser(port1_read_bit_addr),
        .b_ser());
    addr_feeder u_f2 (.clk(clk), .rst(rst), .go(go[2]), .a_val(p2y),
        .b_val(p2c), .addr_en(port2_addr_enable),
        .line_ser(port2_read_line_addr), .a_ser(port2_luma_read_bit_addr),
        .b_ser(port2_chroma_read_bit_addr));
    assign y2 = {4'h0, port2_luma_out};
    assign c2 = {8'h00, port2_chroma_out};

    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pointer step, frozen at the last word of the line
    function automatic int nx(input int p);
        return (p == LINE_WORDS - 1) ? p : p + 1;
    endfunction : nx

    task automatic cmp(input string nm, input logic [11:0] e,
                       input logic [11:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Start a serial address set and wait until writes or reads may go
    task automatic feed(input int k);
        go[k] <= 1'b1;
        @(posedge clk);
        go[k] <= 1'b0;
        repeat (11) @(posedge clk);
    endtask : feed

    // Mode 0 address set, 1 reset to zero, 2 reset to preset
    task automatic wr_line(input int md, input int st, input int n,
                           input logic [31:0] msk);
        pixel_type d;
        if (md == 0) begin
            wa <= 10'(st);
            wp = st;
            wpre = st;
            feed(0);
        end else begin
            write_reset_transfer <= 1'b1;
            write_enable_bit_reset_sel <= (md == 2);
            wp = (md == 2) ? wpre : 0;
            @(posedge clk);
            write_reset_transfer <= 1'b0;
            write_enable_bit_reset_sel <= 1'b0;
            @(posedge clk);
        end
        for (int i = 0; i < n; i++) begin
            d = pixel_type'(12'($urandom));
            {luma_write_data, chroma_write_data} <= d;
            input_mask_enable <= msk[i];
            write_enable_bit_reset_sel <= 1'b1;
            @(posedge clk);
            while (write_ready !== 1'b1) @(posedge clk);
            if (msk[i]) wreg[wp] = d;
            wp = nx(wp);
            // Junk on the data pins must not move a disabled pointer
            write_enable_bit_reset_sel <= 1'b0;
            {luma_write_data, chroma_write_data} <= 12'($urandom);
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
        write_reset_transfer <= 1'b1;
        write_line_increment <= 1'b1;
        @(posedge clk);
        write_reset_transfer <= 1'b0;
        write_line_increment <= 1'b0;
        mem = wreg;
        @(posedge clk);
    endtask : wr_line

    task automatic rd1(input int md, input int st, input int n);
        if (md == 0) begin
            p1a <= 10'(st);
            p1 = st;
            p1pre = st;
            feed(1);
        end else begin
            port1_read_reset <= 1'b1;
            port1_read_enable <= (md == 2);
            p1 = (md == 2) ? p1pre : 0;
            @(posedge clk);
            {port1_read_reset, port1_read_enable} <= 2'b00;
            @(posedge clk);
        end
        for (int i = 0; i < n; i++) begin
            port1_read_enable <= 1'b1;
            q1.push_back(mem[p1]);
            p1 = nx(p1);
            @(posedge clk);
        end
        port1_read_enable <= 1'b0;
        @(posedge clk);
    endtask : rd1

    // Port 2 luma and chroma enables are drawn apart each cycle
    task automatic rd2(input int md, input int ys, input int cs,
                       input int n);
        logic ey, ec;
        if (md == 0) begin
            p2y <= 10'(ys);
            p2c <= 10'(cs);
            {py, pypre, pc, pcpre} = {ys, ys, cs, cs};
            feed(2);
        end else begin
            port2_read_reset <= 1'b1;
            port2_luma_read_enable <= (md == 2);
            port2_chroma_read_enable <= (md == 2);
            py = (md == 2) ? pypre : 0;
            pc = (md == 2) ? pcpre : 0;
            @(posedge clk);
            port2_read_reset <= 1'b0;
            {port2_luma_read_enable, port2_chroma_read_enable} <= 2'b00;
            @(posedge clk);
        end
        for (int i = 0; i < n; i++) begin
            ey = 1'($urandom);
            ec = 1'($urandom);
            port2_luma_read_enable <= ey;
            port2_chroma_read_enable <= ec;
            if (ey) qy.push_back({4'h0, mem[py].luma});
            if (ec) qc.push_back({8'h00, mem[pc].chroma});
            if (ey) py = nx(py);
            if (ec) pc = nx(pc);
            @(posedge clk);
        end
        {port2_luma_read_enable, port2_chroma_read_enable} <= 2'b00;
        @(posedge clk);
    endtask : rd2

    // Note reads taken; give up if the run hangs
    always @(posedge clk) begin
        s1 <= port1_read_enable && !port1_read_reset;
        sy <= port2_luma_read_enable && !port2_read_reset;
        sc <= port2_chroma_read_enable && !port2_read_reset;
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // Compare each read word once it has settled
    always @(negedge clk) begin
        if (s1) cmp("port1_out", q1.pop_front(), port1_out);
        if (sy) cmp("port2_luma_out", qy.pop_front(), y2);
        if (sc) cmp("port2_chroma_out", qc.pop_front(), c2);
    end

    initial begin
        rst = 1'b1;
        {write_enable_bit_reset_sel, input_mask_enable, go} = '0;
        {luma_write_data, chroma_write_data, wa, p1a, p2y, p2c} = '0;
        {write_reset_transfer, write_line_increment} = 2'b00;
        {port1_read_enable, port1_read_reset, port2_read_reset} = 3'b000;
        {port2_luma_read_enable, port2_chroma_read_enable} = 2'b00;
        void'($urandom(32'hbac3));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wr_line(0, 5, 8, 32'hff);
        wr_line(0, 5, 8, 32'had);
        rd1(0, 5, 8);
        wr_line(0, 765, 4, 32'hf);
        rd1(0, 765, 4);
        wr_line(1, 0, 5, 32'h1f);
        rd1(1, 0, 5);
        rd1(2, 0, 3);
        wr_line(2, 0, 2, 32'h3);
        rd1(0, 765, 3);
        rd2(0, 5, 765, 8);
        rd2(1, 0, 0, 6);
        rd2(2, 0, 0, 6);
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule : line_field_memory_ports_tb
`default_nettype wire
